// [rtl/pwmg_cfg.svh]
`ifndef PWMG_CFG_SVH
`define PWMG_CFG_SVH
// ****************************************
// Register offsets (word index)
// ****************************************
`define PWMG_OFS_CTRL 4'h0
`define PWMG_OFS_PDC  4'h1
`define PWMG_OFS_SDC  4'h2
`define PWMG_OFS_PER  4'h3
`define PWMG_OFS_CFG  4'h4
`define PWMG_OFS_DT   4'h5
`define PWMG_OFS_STAT 4'h6
`define PWMG_OFS_CLR  4'h7
`define PWMG_OFS_IEN  4'h8
`define PWMG_OFS_CNT  4'h9
// ****************************************
// Control field positions
// ****************************************
`define PWMG_B_ITB   9
`define PWMG_B_DTHI  7
`define PWMG_B_DTLO  6
`define PWMG_B_MASTER_TIMEBASE_SELECT  3
`define PWMG_B_CAM   2
`define PWMG_B_EXTERNAL_PERIOD_RESET_ENABLE 1
`define PWMG_B_IUE   0
// Configuration field positions
`define PWMG_B_EN    0
`define PWMG_B_OMHI  2
`define PWMG_B_OMLO  1
`define PWMG_B_CURRENT_LIMIT_MODE 3
// Interrupt status bits
`define PWMG_I_PER   0
`define PWMG_I_XRST  1
// ****************************************
// Reset values and limits
// ****************************************
`define PWMG_RST_CTRL 16'h0000
`define PWMG_RST_DUTY 16'h0000
`define PWMG_RST_PER  16'h0100
`define PWMG_RST_DT   16'h0000
`define PWMG_MIN_DUTY 16'h0008
`define PWMG_CAM_MASK 16'hfff8
// ****************************************
// Timing
// ****************************************
`define PWMG_CLK_NS   100
`define PWMG_EDGE_NS  40
`define PWMG_EDGE_CYC \
  (((`PWMG_EDGE_NS) / (`PWMG_CLK_NS)) < 1 ? 1 : \
   ((`PWMG_EDGE_NS) / (`PWMG_CLK_NS)))
`endif

// [rtl/pwmg_deadtime.sv]
`timescale 1ns/100ps
`include "pwmg_cfg.svh"
module pwmg_deadtime import pwmg_pkg::*; (
  input  wire logic         mclk,  // System clock
  input  wire logic         rst,   // Async reset
  input  wire logic         tick,  // Dead-time count enable
  input  pwmg_dtmode_t      mode,  // Dead-time mode
  input  wire logic         compl, // Complementary output mode
  input  wire logic [15:0]  dt,    // Dead-time count
  input  wire logic [1:0]   raw,   // Demanded high/low level
  output logic      [1:0]   out    // Driven pin level
);
  logic [1:0] out_q, out_d;
  logic [1:0][15:0] cnt_q, cnt_d;

  // Per output: delay rising (pos) or, in complementary mode only, falling (neg) edges
  for (genvar i = 0; i < 2; i++) begin : g_ch
    always_comb begin
      logic delayEdge;
      delayEdge = 1'b0;
      out_d[i]  = out_q[i];
      cnt_d[i]  = 16'h0000;
      case (mode)
        PWMG_DT_POS: delayEdge = raw[i];
        PWMG_DT_NEG: delayEdge = !raw[i] && compl;
        default:     delayEdge = 1'b0;
      endcase
      if (raw[i] == out_q[i]) begin
        cnt_d[i] = 16'h0000;
      end else if (!delayEdge || cnt_q[i] >= dt) begin
        out_d[i] = raw[i];
      end else begin
        cnt_d[i] = tick ? 16'(cnt_q[i] + 16'h0001) : cnt_q[i];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_q <= 2'h0;
      cnt_q <= '0;
    end else begin
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end
  assign out = out_q;

  a_dt_none_follow: assert property (@(posedge mclk) disable iff (rst)
    mode == PWMG_DT_NONE |=> out_q == $past(raw))
    else $error("output lagged with dead time off");
  a_dt_pos_fall: assert property (@(posedge mclk) disable iff (rst)
    mode == PWMG_DT_POS && !raw[0] |=> !out_q[0])
    else $error("falling edge delayed in positive mode");
endmodule // pwmg_deadtime

// [rtl/pwmg_pkg.sv]
package pwmg_pkg;
  // Dead-time modes
  typedef enum logic [1:0] {
    PWMG_DT_POS  = 2'b00,
    PWMG_DT_NEG  = 2'b01,
    PWMG_DT_NONE = 2'b10,
    PWMG_DT_RSV  = 2'b11
  } pwmg_dtmode_t;
  // Output modes
  typedef enum logic [1:0] {
    PWMG_OM_COMPL = 2'b00,
    PWMG_OM_REDUN = 2'b01,
    PWMG_OM_PUSH  = 2'b10,
    PWMG_OM_INDEP = 2'b11
  } pwmg_omode_t;
  // Generator control fields
  typedef struct packed {
    logic         independent_timebase_enable;
    pwmg_dtmode_t deadTimeMode;
    logic         master_timebase_select;
    logic         center_align_enable;
    logic         external_period_reset_enable;
    logic         immediate_update_enable;
  } pwmg_ctrl_t;
  // Master time base feed
  typedef struct packed {
    logic        tick;
    logic        sync;
    logic [15:0] period;
  } pwmg_mtb_t;
endpackage

// [rtl/pwmg_timebase.sv]
`timescale 1ns/100ps
`include "pwmg_cfg.svh"
module pwmg_timebase import pwmg_pkg::*; (
  input  wire logic        mclk,   // System clock
  input  wire logic        rst,    // Async reset
  input  wire logic        run,    // Module enabled
  input  wire logic        tick,   // Count enable
  input  wire logic        center, // Up/down counting
  input  wire logic        clear,  // Restart count
  input  wire logic [15:0] period, // Active period
  output logic      [15:0] cnt,    // Count value
  output logic             wrap    // Period boundary
);
  logic [15:0] cnt_q, cnt_d;
  logic        down_q, down_d;

  // Next count: edge ramps, center triangles
  always_comb begin
    cnt_d  = cnt_q;
    down_d = down_q;
    wrap   = 1'b0;
    if (!run || clear) begin
      cnt_d  = 16'h0000;
      down_d = 1'b0;
    end else if (tick && !center) begin
      if (cnt_q >= 16'(period - 16'h0001)) begin
        cnt_d = 16'h0000;
        wrap  = 1'b1;
      end else begin
        cnt_d = 16'(cnt_q + 16'h0001);
      end
    end else if (tick) begin
      if (!down_q && cnt_q >= period) begin
        down_d = 1'b1;
        cnt_d  = 16'(cnt_q - 16'h0001);
      end else if (down_q && cnt_q == 16'h0000) begin
        down_d = 1'b0;
        cnt_d  = 16'h0001;
        wrap   = 1'b1;
      end else if (down_q) begin
        cnt_d = 16'(cnt_q - 16'h0001);
      end else begin
        cnt_d = 16'(cnt_q + 16'h0001);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 16'h0000;
      down_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      down_q <= down_d;
    end
  end
  assign cnt = cnt_q;

  a_edge_wraps: assert property (@(posedge mclk) disable iff (rst)
    run && !clear && tick && !center && period != 16'h0000 &&
    cnt_q >= 16'(period - 16'h0001) |=> cnt_q == 16'h0000)
    else $error("edge count did not wrap");
  a_center_turns: assert property (@(posedge mclk) disable iff (rst)
    run && !clear && tick && center && !down_q && cnt_q >= period
    |=> down_q)
    else $error("center count did not turn down");
endmodule // pwmg_timebase

// [rtl/pwmg_top.sv]
// Behaviour
// - Dead-time mode: positive, negative-complementary, none
// - Time-base select picks secondary master if present
// - Alignment bit chooses center or edge alignment
// - Center alignment only with independent time base
// - Center mode drops low three value bits
// - Current limit restarts independent local time base
// - Immediate or period-boundary shadow transfer
// - Primary duty drives high; both outside independent
// - Secondary duty drives low in independent only
// - Pulse clamped between 8 and period minus 8
// - Resolution coarsens near zero and full duty
// - Control bits five and four read zero
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "pwmg_cfg.svh"
module pwmg_top import pwmg_pkg::*; (
  input  wire logic        mclk,         // 10 MHz clock
  input  wire logic        rst,          // Async reset
  input  wire logic [3:0]  regAddr,      // Register index
  input  wire logic [15:0] regWdata,     // Write data
  input  wire logic        regWr,        // Write strobe
  input  wire logic        regRd,        // Read strobe
  output logic      [15:0] regRdata,     // Read data, next cycle
  input  pwmg_mtb_t        priTb,        // Primary master time base
  input  pwmg_mtb_t        secTb,        // Secondary master time base
  input  wire logic        secPresent,   // Secondary base exists
  input  wire logic        currentLimit, // Current-limit pin
  output logic             pwmHigh,      // High output pin
  output logic             pwmLow,       // Low output pin
  output logic             irq           // Level interrupt
);
  // ****************************************
  // State
  // ****************************************
  pwmg_ctrl_t  ctrl_q, ctrl_d;
  pwmg_omode_t omode_q, omode_d;
  logic        enable_q, enable_d, clMode_q, clMode_d;
  logic [15:0] pdc_q, pdc_d, sdc_q, sdc_d, per_q, per_d, dt_q, dt_d;
  logic [15:0] pdcAct_q, pdcAct_d, sdcAct_q, sdcAct_d;
  logic [15:0] perAct_q, perAct_d, dtAct_q, dtAct_d;
  logic [1:0]  stat_q, stat_d, ien_q, ien_d;
  logic [15:0] rdata_q, rdata_d;
  logic        irq_q, irq_d, phase_q, phase_d;
  logic        cl1_q, cl2_q;
  logic        center, tick, mSync, xReset, wrap, active;
  logic [15:0] period, cnt, pdcEff, sdcEff, dtEff;
  logic [1:0]  raw, pinOut;
  logic        wrCtrl, wrPdc, wrSdc, wrPer, wrDt;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cl1_q <= 1'b0;
      cl2_q <= 1'b0;
    end else begin
      cl1_q <= currentLimit;
      cl2_q <= cl1_q;
    end
  end

  // ****************************************
  // Time base selection
  // ****************************************
  // Secondary base only when requested and present
  always_comb begin
    if (ctrl_q.master_timebase_select && secPresent) begin
      tick  = secTb.tick;
      mSync = secTb.sync;
    end else begin
      tick  = priTb.tick;
      mSync = priTb.sync;
    end
  end
  assign center = ctrl_q.center_align_enable && ctrl_q.independent_timebase_enable;
  assign period = ctrl_q.independent_timebase_enable ? perAct_q
                : (ctrl_q.master_timebase_select && secPresent) ? secTb.period
                : priTb.period;
  // Current limit restarts only the independent base
  assign xReset = ctrl_q.external_period_reset_enable && ctrl_q.independent_timebase_enable && !clMode_q
                  && cl2_q && enable_q;

  pwmg_timebase u_tb (
    .mclk   (mclk),
    .rst    (rst),
    .run    (enable_q),
    .tick   (tick),
    .center (center),
    .clear  (xReset || (!ctrl_q.independent_timebase_enable && mSync)),
    .period (period),
    .cnt    (cnt),
    .wrap   (wrap)
  );

  // ****************************************
  // Effective duty values
  // ****************************************
  function automatic logic [15:0] effDuty(input logic [15:0] d,
                                          input logic [15:0] p,
                                          input logic        c);
    logic [15:0] v, hi, edgeW;
    v     = c ? (d & `PWMG_CAM_MASK) : d;
    edgeW = 16'(`PWMG_EDGE_CYC);
    hi    = 16'(p - `PWMG_MIN_DUTY);
    if (c) hi = hi & `PWMG_CAM_MASK;
    // Coarser steps close to either end
    if (v < 16'(`PWMG_MIN_DUTY + edgeW) ||
        v > 16'(hi - edgeW))
      v = v & `PWMG_CAM_MASK;
    if (v < `PWMG_MIN_DUTY)
      v = `PWMG_MIN_DUTY;
    else if (v > hi)
      v = hi;
    return v;
  endfunction

  assign pdcEff = effDuty(pdcAct_q, period, center);
  assign sdcEff = effDuty(sdcAct_q, period, center);
  assign dtEff  = center ? (dtAct_q & `PWMG_CAM_MASK) : dtAct_q;
  assign active = cnt < pdcEff;

  // ****************************************
  // Output mode steering
  // ****************************************
  always_comb begin
    raw = 2'b00;
    case (omode_q)
      PWMG_OM_INDEP: raw = {active, cnt < sdcEff};
      PWMG_OM_COMPL: raw = {active, !active};
      PWMG_OM_REDUN: raw = {active, active};
      PWMG_OM_PUSH:  raw = {active && !phase_q,
                            active && phase_q};
      default:       raw = 2'b00;
    endcase
    if (!enable_q)
      raw = 2'b00;
  end

  pwmg_deadtime u_dt (
    .mclk  (mclk),
    .rst   (rst),
    .tick  (tick),
    .mode  (ctrl_q.deadTimeMode),
    .compl (omode_q == PWMG_OM_COMPL),
    .dt    (dtEff),
    .raw   (raw),
    .out   (pinOut)
  );
  assign pwmHigh = pinOut[1];
  assign pwmLow  = pinOut[0];

  // ****************************************
  // Register writes and shadow transfer
  // ****************************************
  assign wrCtrl = regWr && regAddr == `PWMG_OFS_CTRL;
  assign wrPdc  = regWr && regAddr == `PWMG_OFS_PDC;
  assign wrSdc  = regWr && regAddr == `PWMG_OFS_SDC;
  assign wrPer  = regWr && regAddr == `PWMG_OFS_PER;
  assign wrDt   = regWr && regAddr == `PWMG_OFS_DT;

  always_comb begin
    ctrl_d   = ctrl_q;
    omode_d  = omode_q;
    enable_d = enable_q;
    clMode_d = clMode_q;
    pdc_d    = wrPdc ? regWdata : pdc_q;
    sdc_d    = wrSdc ? regWdata : sdc_q;
    per_d    = wrPer ? regWdata : per_q;
    dt_d     = wrDt ? regWdata : dt_q;
    pdcAct_d = pdcAct_q;
    sdcAct_d = sdcAct_q;
    perAct_d = perAct_q;
    dtAct_d  = dtAct_q;
    ien_d    = ien_q;
    if (wrCtrl) begin
      ctrl_d.independent_timebase_enable          = regWdata[`PWMG_B_ITB];
      ctrl_d.deadTimeMode = pwmg_dtmode_t'(
        regWdata[`PWMG_B_DTHI:`PWMG_B_DTLO]);
      ctrl_d.master_timebase_select  = regWdata[`PWMG_B_MASTER_TIMEBASE_SELECT];
      ctrl_d.center_align_enable   = regWdata[`PWMG_B_CAM];
      ctrl_d.external_period_reset_enable = regWdata[`PWMG_B_EXTERNAL_PERIOD_RESET_ENABLE];
      ctrl_d.immediate_update_enable   = regWdata[`PWMG_B_IUE];
    end
    if (regWr && regAddr == `PWMG_OFS_CFG) begin
      enable_d = regWdata[`PWMG_B_EN];
      omode_d  = pwmg_omode_t'(regWdata[`PWMG_B_OMHI:`PWMG_B_OMLO]);
      clMode_d = regWdata[`PWMG_B_CURRENT_LIMIT_MODE];
    end
    if (regWr && regAddr == `PWMG_OFS_IEN)
      ien_d = regWdata[1:0];
    // Active copies load now or at the boundary
    if (ctrl_q.immediate_update_enable) begin
      pdcAct_d = pdc_d;
      sdcAct_d = sdc_d;
      perAct_d = per_d;
      dtAct_d  = dt_d;
    end else if (wrap) begin
      pdcAct_d = pdc_q;
      sdcAct_d = sdc_q;
      perAct_d = per_q;
      dtAct_d  = dt_q;
    end
  end

  // ****************************************
  // Status, interrupt and read data
  // ****************************************
  always_comb begin
    logic [1:0] clr;
    clr = (regWr && regAddr == `PWMG_OFS_CLR) ? regWdata[1:0] : 2'b00;
    // Hardware set wins over a clear in the same cycle
    stat_d = (stat_q & ~clr) | {xReset, wrap};
    irq_d  = |(stat_d & ien_d);
    phase_d = wrap ? !phase_q : phase_q;
    if (!enable_q)
      phase_d = 1'b0;
    rdata_d = 16'h0000;
    if (regRd) begin
      case (regAddr)
        `PWMG_OFS_CTRL: begin
          rdata_d[`PWMG_B_ITB] = ctrl_q.independent_timebase_enable;
          rdata_d[`PWMG_B_DTHI:`PWMG_B_DTLO] = ctrl_q.deadTimeMode;
          rdata_d[`PWMG_B_MASTER_TIMEBASE_SELECT]  = ctrl_q.master_timebase_select;
          rdata_d[`PWMG_B_CAM]   = ctrl_q.center_align_enable;
          rdata_d[`PWMG_B_EXTERNAL_PERIOD_RESET_ENABLE] = ctrl_q.external_period_reset_enable;
          rdata_d[`PWMG_B_IUE]   = ctrl_q.immediate_update_enable; // bits 5:4 stay 0
        end
        `PWMG_OFS_PDC:  rdata_d = pdc_q;
        `PWMG_OFS_SDC:  rdata_d = sdc_q;
        `PWMG_OFS_PER:  rdata_d = per_q;
        `PWMG_OFS_DT:   rdata_d = dt_q;
        `PWMG_OFS_CFG:  rdata_d = {12'h000, clMode_q, omode_q, enable_q};
        `PWMG_OFS_STAT: rdata_d = {14'h0000, stat_q};
        `PWMG_OFS_IEN:  rdata_d = {14'h0000, ien_q};
        `PWMG_OFS_CNT:  rdata_d = cnt;
        default:        rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= pwmg_ctrl_t'(7'(`PWMG_RST_CTRL));
      omode_q  <= PWMG_OM_COMPL;
      enable_q <= 1'b0;
      clMode_q <= 1'b0;
      pdc_q    <= `PWMG_RST_DUTY;
      sdc_q    <= `PWMG_RST_DUTY;
      per_q    <= `PWMG_RST_PER;
      dt_q     <= `PWMG_RST_DT;
      pdcAct_q <= `PWMG_RST_DUTY;
      sdcAct_q <= `PWMG_RST_DUTY;
      perAct_q <= `PWMG_RST_PER;
      dtAct_q  <= `PWMG_RST_DT;
      stat_q   <= 2'b00;
      ien_q    <= 2'b00;
      rdata_q  <= 16'h0000;
      irq_q    <= 1'b0;
      phase_q  <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      omode_q  <= omode_d;
      enable_q <= enable_d;
      clMode_q <= clMode_d;
      pdc_q    <= pdc_d;
      sdc_q    <= sdc_d;
      per_q    <= per_d;
      dt_q     <= dt_d;
      pdcAct_q <= pdcAct_d;
      sdcAct_q <= sdcAct_d;
      perAct_q <= perAct_d;
      dtAct_q  <= dtAct_d;
      stat_q   <= stat_d;
      ien_q    <= ien_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
      phase_q  <= phase_d;
    end
  end
  assign regRdata = rdata_q;
  assign irq      = irq_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_ctrl_gap_zero: assert property (
    regRd && regAddr == `PWMG_OFS_CTRL |=> regRdata[5:4] == 2'b00)
    else $error("control bits 5:4 not zero");
  a_no_itb_edge: assert property (!ctrl_q.independent_timebase_enable |-> !center)
    else $error("center mode without independent base");
  a_cam_center: assert property (
    ctrl_q.center_align_enable && ctrl_q.independent_timebase_enable |-> center)
    else $error("center mode not selected");
  a_sec_tick_used: assert property (
    ctrl_q.master_timebase_select && secPresent |-> tick == secTb.tick)
    else $error("secondary time base not used");
  a_iue_immediate: assert property (
    ctrl_q.immediate_update_enable && wrPdc |=> pdcAct_q == $past(regWdata))
    else $error("immediate duty update missed");
  a_sync_hold: assert property (
    !ctrl_q.immediate_update_enable && !wrap |=> $stable(pdcAct_q))
    else $error("duty changed off boundary");
  a_duty_floor: assert property (
    period >= 16'h0010 |-> pdcEff >= `PWMG_MIN_DUTY)
    else $error("duty below minimum pulse");
  a_center_coarse: assert property (
    center |-> pdcEff[2:0] == 3'h0 && dtEff[2:0] == 3'h0)
    else $error("center mode kept low bits");
  a_xres_clears: assert property (
    xReset |=> cnt == 16'h0000 && stat_q[`PWMG_I_XRST])
    else $error("current limit did not restart base");
  a_compl_pair: assert property (
    enable_q && omode_q == PWMG_OM_COMPL |-> raw[0] == !raw[1])
    else $error("complementary pair broken");
  a_indep_low: assert property (
    enable_q && omode_q == PWMG_OM_INDEP |-> raw[0] == (cnt < sdcEff))
    else $error("low output not from secondary duty");
  a_irq_level: assert property (
    |(stat_q & ien_q) |-> ##[0:1] irq_q)
    else $error("interrupt not raised");
  c_center_run: cover property (center && wrap);
  c_xres_event: cover property (xReset ##1 irq_q);
  c_sync_load: cover property (!ctrl_q.immediate_update_enable && wrPdc ##[1:300] wrap);
endmodule // pwmg_top

// [tb/pwmg_stage.sv]
`timescale 1ns/100ps
// ****************************************
// Power stage model: gate pulse meter
// ****************************************
module pwmg_stage (
  input  wire logic        mclk,    // System clock
  input  wire logic        rst,     // Async reset
  input  wire logic        pwmHigh, // High switch gate
  input  wire logic        pwmLow,  // Low switch gate
  output logic      [15:0] hiWidth, // Last high pulse length
  output logic      [15:0] loWidth  // Last low pulse length
);
  logic [15:0] hiRun;
  logic [15:0] loRun;
  // Latch the length of each finished gate pulse
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      hiRun   <= 16'h0000;
      loRun   <= 16'h0000;
      hiWidth <= 16'h0000;
      loWidth <= 16'h0000;
    end else begin
      hiRun <= pwmHigh ? hiRun + 16'h0001 : 16'h0000;
      loRun <= pwmLow ? loRun + 16'h0001 : 16'h0000;
      if (!pwmHigh && hiRun != 16'h0000) hiWidth <= hiRun;
      if (!pwmLow && loRun != 16'h0000) loWidth <= loRun;
    end
  end
endmodule // pwmg_stage

// [tb/pwmg_top_bench.sv]
`timescale 1ns/100ps
`include "pwmg_cfg.svh"
module pwmg_top_bench import pwmg_pkg::*;;
  logic        mclk;
  logic        rst;
  logic [3:0]  regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  pwmg_mtb_t   priTb;
  pwmg_mtb_t   secTb;
  logic        secPresent;
  logic        currentLimit;
  logic        pwmHigh;
  logic        pwmLow;
  logic        irq;
  logic [15:0] hiWidth;
  logic [15:0] loWidth;
  int          mismatches;
  int          nTests;
  // ****************************************
  // Design, far side and clock
  // ****************************************
  pwmg_top dut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .priTb(priTb), .secTb(secTb),
    .secPresent(secPresent), .currentLimit(currentLimit),
    .pwmHigh(pwmHigh), .pwmLow(pwmLow), .irq(irq));
  pwmg_stage stage (.mclk(mclk), .rst(rst), .pwmHigh(pwmHigh),
    .pwmLow(pwmLow), .hiWidth(hiWidth), .loWidth(loWidth));
  // 10 MHz clock
  always #50 mclk = ~mclk;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic waitCyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // Mode bits only change while the module is stopped
  task automatic setup(input logic [15:0] ctrl, input logic [15:0] cfg);
    wr(`PWMG_OFS_CFG, 16'h0000);
    wr(`PWMG_OFS_CTRL, ctrl);
    wr(`PWMG_OFS_CFG, cfg);
  endtask
  task automatic dutyHi(input logic [15:0] d, input logic [15:0] e);
    wr(`PWMG_OFS_PDC, d);
    waitCyc(130);
    chk(hiWidth, e);
  endtask
  task automatic stopTest;
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic tRegs;
    rdChk(`PWMG_OFS_CTRL, 16'h0000);
    rdChk(`PWMG_OFS_PDC, 16'h0000);
    rdChk(`PWMG_OFS_SDC, 16'h0000);
    rdChk(`PWMG_OFS_PER, `PWMG_RST_PER);
    wr(`PWMG_OFS_CTRL, 16'hffff);
    rdChk(`PWMG_OFS_CTRL, 16'h02cf);
    wr(`PWMG_OFS_SDC, 16'ha5c3);
    rdChk(`PWMG_OFS_SDC, 16'ha5c3);
    wr(4'hf, 16'h1234);
    rdChk(4'hf, 16'h0000);
    rdChk(`PWMG_OFS_CLR, 16'h0000);
    $display("test registers done");
  endtask
  task automatic tEdge;
    setup(16'h0081, 16'h0001);
    wr(`PWMG_OFS_PER, 16'h0020);
    dutyHi(16'h0000, 16'h0008);
    dutyHi(16'h000c, 16'h000c);
    chk(loWidth, 16'h0014);
    dutyHi(16'h0020, 16'h0018);
    $display("test edge done");
  endtask
  task automatic tDead;
    logic [3:0][15:0] exp;
    exp = {16'h0010, 16'h0010, 16'h0012, 16'h000e};
    wr(`PWMG_OFS_DT, 16'h0002);
    for (int m = 0; m < 4; m++) begin
      setup(16'h0001 | 16'(m << 6), 16'h0001);
      dutyHi(16'h0010, exp[m]);
      chk(loWidth, exp[m]);
    end
    $display("test deadtime done");
  endtask
  task automatic tIndep;
    setup(16'h0081, 16'h0007);
    wr(`PWMG_OFS_SDC, 16'h0014);
    dutyHi(16'h000c, 16'h000c);
    chk(loWidth, 16'h0014);
    $display("test independent done");
  endtask
  task automatic tCenter;
    logic [15:0] w;
    setup(16'h0085, 16'h0001);
    dutyHi(16'h000c, 16'h000c);
    setup(16'h0285, 16'h0001);
    dutyHi(16'h0010, 16'h001f);
    w = hiWidth;
    chk({15'h0000, w > 16'h0010}, 16'h0001);
    dutyHi(16'h0017, 16'h001f);
    $display("test center done");
  endtask
  task automatic tSelect;
    logic [15:0] a;
    logic [15:0] b;
    secPresent <= 1'b1;
    setup(16'h0089, 16'h0001);
    rd(`PWMG_OFS_CNT, a);
    waitCyc(5);
    rd(`PWMG_OFS_CNT, b);
    chk(b, a);
    setup(16'h0081, 16'h0001);
    rd(`PWMG_OFS_CNT, a);
    rd(`PWMG_OFS_CNT, b);
    chk({15'h0000, a != b}, 16'h0001);
    $display("test select done");
  endtask
  task automatic tExtReset;
    logic [15:0] s;
    for (int x = 0; x < 2; x++) begin
      setup(16'h0201 | 16'(x << 1), 16'h0001);
      wr(`PWMG_OFS_CLR, 16'h0002);
      @(posedge mclk) currentLimit <= 1'b1;
      waitCyc(6);
      rd(`PWMG_OFS_STAT, s);
      chk(s & 16'h0002, 16'(x << 1));
      rd(`PWMG_OFS_CNT, s);
      if (x == 1) chk(s, 16'h0000);
      @(posedge mclk) currentLimit <= 1'b0;
    end
    wr(`PWMG_OFS_CLR, 16'h0002);
    $display("test external reset done");
  endtask
  task automatic tIrq;
    logic [15:0] s;
    wr(`PWMG_OFS_IEN, 16'h0001);
    waitCyc(40);
    chk({15'h0000, irq}, 16'h0001);
    rd(`PWMG_OFS_STAT, s);
    chk(s & 16'h0001, 16'h0001);
    wr(`PWMG_OFS_IEN, 16'h0000);
    waitCyc(2);
    chk({15'h0000, irq}, 16'h0000);
    wr(`PWMG_OFS_CFG, 16'h0000);
    waitCyc(3);
    wr(`PWMG_OFS_CLR, 16'h0003);
    rdChk(`PWMG_OFS_STAT, 16'h0000);
    $display("test interrupt done");
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    mclk         = 1'b0;
    rst          = 1'b1;
    regAddr      = 4'h0;
    regWdata     = 16'h0000;
    regWr        = 1'b0;
    regRd        = 1'b0;
    priTb        = '{tick: 1'b1, sync: 1'b0, period: 16'h0020};
    secTb        = '{tick: 1'b0, sync: 1'b0, period: 16'h0020};
    secPresent   = 1'b0;
    currentLimit = 1'b0;
    mismatches   = 0;
    nTests       = 0;
    waitCyc(6);
    rst <= 1'b0;
    tRegs();
    tEdge();
    tDead();
    tIndep();
    tCenter();
    tSelect();
    tExtReset();
    tIrq();
    stopTest();
  end
  initial begin
    #(100 * 20000);
    mismatches++;
    stopTest();
  end
endmodule // pwmg_top_bench
